// *** hdl/gpd_top.v ***
`timescale 1ns/10ps
`default_nettype none
`include "gpd_defs.vh"

// Overview of operation
// - direction bit zero makes the pin an output
// - direction bit one makes the pin an input, driver off
// - set register write drives ones where written bits are one
// - clear register write drives zeros where written bits are one
// - output data write replaces the output state in the enabled byte lanes
// - set, clear and output data reads return stored output state
// - output writes update stored state of pins configured as inputs but do not drive them
// - input data of an input pin is the synchronized pin level, taken after the filter on pins seven to zero
// - input data of an output pin is the driven value
// - open-drain pins read the wired line level
// - only pins seven to zero carry a filter, one register each
// - filter register holds enable bit and interval field
// - enabled filter idles until raw differs from filtered state
// - level held through the interval passes downstream
// - raw change before the count ends restarts count from zero
// - enabled filter delays every accepted change by the interval
// - interval counter advances at half the clock rate
// - software reset leaves configuration and output state unchanged
// - hardware reset returns all registers to default values
// - pins group into banks of sixteen consecutive signals
module gpd_top #(
  parameter NPAIR = 2,
  parameter IW = 16,
  parameter [31:0] OD_MASK = 32'h00000000
) (
  input wire clk,
  input wire rst_n,
  input wire [7:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_writedata,
  input wire [3:0] avs_byteenable,
  output reg [31:0] avs_readdata,
  output wire avs_waitrequest,
  input wire [NPAIR*32-1:0] pin_in,
  output wire [NPAIR*32-1:0] pin_out,
  output wire [NPAIR*32-1:0] pin_oe,
  output reg soft_reset_pulse
);

  localparam NP = NPAIR * 32;
  localparam NBANK = NP / 16;

  reg [NP-1:0] dir_q;
  reg [NP-1:0] out_q;
  reg [NP-1:0] sync1_q;
  reg [NP-1:0] sync2_q;
  reg [31:0] filt_q [0:7];
  reg half_q;
  reg ack_q;
  wire [NP-1:0] in_data;
  wire [7:0] filt_out;
  wire [31:0] wmask;
  wire acc;
  wire wr;

  // ==========================================================
  // bus handshake: one wait cycle on every access
  assign acc = avs_read | avs_write;
  assign avs_waitrequest = acc & ~ack_q;
  // write lands only at the edge where waitrequest is low
  assign wr = avs_write & ack_q;
  assign wmask = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
                  {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};

  always @(posedge clk) begin
    if (!rst_n) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= acc & ~ack_q;
    end
  end

  // ==========================================================
  // half-rate enable for the filter counters
  always @(posedge clk) begin
    if (!rst_n) begin
      half_q <= 1'b0;
    end else begin
      half_q <= ~half_q;
    end
  end

  // ==========================================================
  // pin synchronizers
  always @(posedge clk) begin
    if (!rst_n) begin
      sync1_q <= {NP{1'b0}};
      sync2_q <= {NP{1'b0}};
    end else begin
      sync1_q <= pin_in;
      sync2_q <= sync1_q;
    end
  end

  // ==========================================================
  // per-pair direction and output registers
  genvar p;
  generate
    for (p = 0; p < NPAIR; p = p + 1) begin : g_pair
      wire [7:0] base;
      assign base = p * `GPD_PAIR_STRIDE;
      always @(posedge clk) begin
        if (!rst_n) begin
          dir_q[p*32 +: 32] <= `GPD_DIR_RST;
          out_q[p*32 +: 32] <= `GPD_OUT_RST;
        end else if (wr) begin
          if (avs_address == base + `GPD_OFS_DIR) begin
            dir_q[p*32 +: 32] <= (dir_q[p*32 +: 32] & ~wmask) | (avs_writedata & wmask);
          end
          if (avs_address == base + `GPD_OFS_OUT) begin
            out_q[p*32 +: 32] <= (out_q[p*32 +: 32] & ~wmask) | (avs_writedata & wmask);
          end
          if (avs_address == base + `GPD_OFS_SET) begin
            out_q[p*32 +: 32] <= out_q[p*32 +: 32] | (avs_writedata & wmask);
          end
          if (avs_address == base + `GPD_OFS_CLR) begin
            out_q[p*32 +: 32] <= out_q[p*32 +: 32] & ~(avs_writedata & wmask);
          end
        end
      end
    end
  endgenerate

  // ==========================================================
  // filter control registers and filters on pins 7..0
  genvar f;
  generate
    for (f = 0; f < 8; f = f + 1) begin : g_filt
      always @(posedge clk) begin
        if (!rst_n) begin
          filt_q[f] <= `GPD_FILT_RST;
        end else if (wr && avs_address == `GPD_OFS_FILT0 + 4 * f) begin
          filt_q[f] <= (filt_q[f] & ~wmask) | (avs_writedata & wmask);
        end
      end
      gpd_filter #(.IW(IW)) u_filt (
        .clk(clk),
        .rst_n(rst_n),
        .tick(half_q),
        .enable(filt_q[f][`GPD_FILT_EN_BIT]),
        .interval(filt_q[f][`GPD_FILT_IVL_MSB:`GPD_FILT_IVL_LSB]),
        .raw(sync2_q[f]),
        .filt(filt_out[f])
      );
    end
  endgenerate

  // ==========================================================
  // pin drive and input readback
  genvar b;
  generate
    for (b = 0; b < NP; b = b + 1) begin : g_pin
      wire od;
      wire lvl;
      assign od = OD_MASK[b % 32];
      assign lvl = (b < 8) ? filt_out[b] : sync2_q[b];
      // inputs never drive
      assign pin_oe[b] = ~dir_q[b] & (od ? ~out_q[b] : 1'b1);
      assign pin_out[b] = od ? 1'b0 : out_q[b];
      // open-drain reads the wired level
      assign in_data[b] = (dir_q[b] | od) ? lvl : out_q[b];
    end
  endgenerate

  // ==========================================================
  // read mux and software reset strobe
  integer i;
  always @(posedge clk) begin
    if (!rst_n) begin
      avs_readdata <= 32'h00000000;
      soft_reset_pulse <= 1'b0;
    end else begin
      // software reset touches no register here
      soft_reset_pulse <= wr && avs_address == `GPD_OFS_SWRST && avs_writedata[0];
      if (avs_read && !ack_q) begin
        avs_readdata <= 32'h00000000;
        for (i = 0; i < NPAIR; i = i + 1) begin
          if (avs_address == i * `GPD_PAIR_STRIDE + `GPD_OFS_DIR) begin
            avs_readdata <= dir_q[i*32 +: 32];
          end
          if (avs_address == i * `GPD_PAIR_STRIDE + `GPD_OFS_OUT ||
              avs_address == i * `GPD_PAIR_STRIDE + `GPD_OFS_SET ||
              avs_address == i * `GPD_PAIR_STRIDE + `GPD_OFS_CLR) begin
            avs_readdata <= out_q[i*32 +: 32];
          end
          if (avs_address == i * `GPD_PAIR_STRIDE + `GPD_OFS_IN) begin
            avs_readdata <= in_data[i*32 +: 32];
          end
        end
        for (i = 0; i < 8; i = i + 1) begin
          if (avs_address == `GPD_OFS_FILT0 + 4 * i) begin
            avs_readdata <= filt_q[i];
          end
        end
      end
    end
  end

endmodule

`default_nettype wire

// *** hdl/gpd_defs.vh ***
`ifndef GPD_DEFS_VH
`define GPD_DEFS_VH

// ==========================================================
// register byte offsets, one word per 32-pin bank pair except the shared filter and soft reset words
`define GPD_OFS_DIR 8'h00
`define GPD_OFS_OUT 8'h04
`define GPD_OFS_SET 8'h08
`define GPD_OFS_CLR 8'h0C
`define GPD_OFS_IN 8'h10
`define GPD_PAIR_STRIDE 8'h20
`define GPD_OFS_FILT0 8'hC0
`define GPD_OFS_SWRST 8'hE0

// ==========================================================
// field positions of a pin filter control word
`define GPD_FILT_EN_BIT 31
`define GPD_FILT_IVL_MSB 15
`define GPD_FILT_IVL_LSB 0

// ==========================================================
// reset values
`define GPD_DIR_RST 32'hFFFFFFFF
`define GPD_OUT_RST 32'h00000000
`define GPD_FILT_RST 32'h00000000

`endif

// *** hdl/gpd_filter.v ***
`timescale 1ns/10ps
`default_nettype none

module gpd_filter #(
  parameter IW = 16
) (
  input wire clk,
  input wire rst_n,
  input wire tick,
  input wire enable,
  input wire [IW-1:0] interval,
  input wire raw,
  output wire filt
);

  reg state_q;
  reg [IW-1:0] cnt_q;

  // ==========================================================
  // debounce counter
  always @(posedge clk) begin
    if (!rst_n) begin
      state_q <= 1'b0;
      cnt_q <= {IW{1'b0}};
    end else if (!enable) begin
      state_q <= raw;
      cnt_q <= {IW{1'b0}};
    end else if (raw == state_q) begin
      cnt_q <= {IW{1'b0}};
    end else if (tick) begin
      if (cnt_q + {{(IW-1){1'b0}}, 1'b1} >= interval) begin
        state_q <= raw;
        cnt_q <= {IW{1'b0}};
      end else begin
        cnt_q <= cnt_q + {{(IW-1){1'b0}}, 1'b1};
      end
    end
  end

  assign filt = enable ? state_q : raw;

endmodule

`default_nettype wire

// *** sim/gpd_pins.sv ***
`timescale 1ns/10ps
`default_nettype none
// ==========================================
// board side of the pins
module gpd_pins #(
  parameter [31:0] OD_MASK = 32'h00000000
) (
  input wire logic [31:0] pin_out,
  input wire logic [31:0] pin_oe,
  input wire logic [31:0] ext,
  output wire logic [31:0] pin_in
);
  // open-drain lines wired-and with the board, others follow the driver when enabled, else the board
  assign pin_in = (OD_MASK & ext & (~pin_oe | pin_out)) |
                  (~OD_MASK & ((pin_oe & pin_out) | (~pin_oe & ext)));
endmodule
`default_nettype wire

// *** sim/gpd_top_asserts.sv ***
`timescale 1ns/10ps
`default_nettype none
// ==========================================
// port checks
module gpd_chk #(
  parameter NPAIR = 2
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  input wire logic [NPAIR*32-1:0] pin_out,
  input wire logic [NPAIR*32-1:0] pin_oe,
  input wire logic soft_reset_pulse
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  wait_first_a: assert property ($rose(avs_read || avs_write) |-> avs_waitrequest)
    else $error("no wait in first access cycle");
  one_wait_a: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("more than one wait cycle");
  dir_cause_a: assert property (!$stable(pin_oe) |-> $past(avs_write && !avs_waitrequest &&
    avs_address[4:0] <= 5'h0C && avs_address[7:5] < NPAIR)) else $error("oe moved without dir write");
  out_cause_a: assert property (!$stable(pin_out) |-> $past(avs_write && !avs_waitrequest))
    else $error("pin out moved without write");
  soft_pulse_a: assert property (soft_reset_pulse |=> !soft_reset_pulse)
    else $error("soft reset pulse too long");
  soft_cause_a: assert property (soft_reset_pulse |-> $past(avs_write && avs_address == 8'hE0) ||
    $past(avs_write && avs_address == 8'hE0, 2)) else $error("soft reset pulse without write");
  soft_keep_a: assert property (soft_reset_pulse |=> $stable(pin_oe) && $stable(pin_out))
    else $error("soft reset changed pins");
  hole_zero_a: assert property (avs_read && !avs_waitrequest && avs_address == 8'h14
    |-> avs_readdata == 32'h00000000) else $error("unmapped read not zero");
  hw_reset_a: assert property (disable iff (1'b0) !rst_n |=> pin_oe == '0)
    else $error("pins driven after reset");
endmodule
bind gpd_top gpd_chk #(.NPAIR(NPAIR)) u_chk (.clk(clk), .rst_n(rst_n), .avs_address(avs_address),
  .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .pin_out(pin_out),
  .pin_oe(pin_oe), .soft_reset_pulse(soft_reset_pulse));
`default_nettype wire

// *** sim/tb_gpio_pin_data_debounce.sv ***
`timescale 1ns/10ps
`default_nettype none
// ==========================================
// bench
module tb_gpio_pin_data_debounce;
  logic clk = 0, rst_n = 0, avs_read = 0, avs_write = 0;
  logic [7:0] avs_address = 8'h00;
  logic [31:0] avs_writedata = 32'h0, ext = 32'hCAFE0000, q;
  wire logic [31:0] avs_readdata, pin_in, pin_out, pin_oe;
  wire logic avs_waitrequest, soft_reset_pulse;
  int errors = 0, tests_run = 0;
  logic [72:0] rows [15] = '{{1'h0,8'h00,32'h0,32'hFFFFFFFF}, {1'h0,8'h04,32'h0,32'h0},
    {1'h1,8'h04,32'hA5A50000,32'h0}, {1'h0,8'h04,32'h0,32'hA5A50000},
    {1'h1,8'h00,32'hFFFF0000,32'h0}, {1'h1,8'h08,32'h000000FF,32'h0},
    {1'h0,8'h08,32'h0,32'hA5A500FF}, {1'h1,8'h0C,32'h0000000F,32'h0},
    {1'h0,8'h0C,32'h0,32'hA5A500F0}, {1'h1,8'h04,32'h12345678,32'h0},
    {1'h1,8'h14,32'hFFFFFFFF,32'h0}, {1'h0,8'h14,32'h0,32'h0}, {1'h1,8'hE0,32'h1,32'h0},
    {1'h0,8'h04,32'h0,32'h12345678}, {1'h0,8'h00,32'h0,32'hFFFF0000}};
  always #5 clk = ~clk;
  gpd_top #(.NPAIR(1), .IW(16), .OD_MASK(32'h00008000)) dut (.clk(clk), .rst_n(rst_n),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(4'hF), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
    .soft_reset_pulse(soft_reset_pulse));
  gpd_pins #(.OD_MASK(32'h00008000)) u_pins (.pin_out(pin_out), .pin_oe(pin_oe), .ext(ext),
    .pin_in(pin_in));
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= !wr;
    @(posedge clk);
    while (avs_waitrequest !== 1'b0) @(posedge clk);
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    @(posedge clk);
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task summarize;
    $display("tests_run=%0d errors=%0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    #100000;
    errors++;
    summarize;
  end
  initial begin
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    foreach (rows[i]) begin
      bus(rows[i][72], rows[i][71:64], rows[i][63:32]);
      if (!rows[i][72]) chk(q, rows[i][31:0]);
    end
    chk(pin_oe, 32'h0000FFFF);
    chk(pin_out & pin_oe, 32'h00005678);
    bus(1'h1, 8'h08, 32'h00008000);
    repeat (4) @(posedge clk);
    bus(1'h0, 8'h10, 32'h0);
    chk(q, 32'hCAFE5678);
    $display("register and pin test done");
    bus(1'h1, 8'hC0, 32'h80000003);
    bus(1'h1, 8'h00, 32'hFFFF0001);
    ext[0] <= 1'b1;
    repeat (3) @(posedge clk);
    ext[0] <= 1'b0;
    repeat (10) @(posedge clk);
    bus(1'h0, 8'h10, 32'h0);
    chk(q & 32'h1, 32'h0);
    ext[0] <= 1'b1;
    @(posedge clk);
    bus(1'h0, 8'h10, 32'h0);
    chk(q & 32'h1, 32'h0);
    repeat (20) @(posedge clk);
    bus(1'h0, 8'h10, 32'h0);
    chk(q & 32'h1, 32'h1);
    $display("filter test done");
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    chk(pin_oe, 32'h0);
    bus(1'h0, 8'h00, 32'h0);
    chk(q, 32'hFFFFFFFF);
    bus(1'h0, 8'hC0, 32'h0);
    chk(q, 32'h0);
    $display("reset test done");
    summarize;
  end
endmodule
`default_nettype wire
